/* rtl/eeprom_page_host.sv */
// Host controller that writes pages to a parallel EEPROM and detects completion
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_page_host_defs.svh"
module eeprom_page_host (
  input wire logic clk,
  input wire logic reset,
  input wire logic page_valid,
  input wire logic [9:0] page_select_address,
  input wire logic [6:0] page_count_m1,
  input wire eeprom_page_host_pkg::done_mode_t done_mode,
  output logic page_ready,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready,
  output logic page_done,
  output logic busy,
  output logic [16:0] mem_addr,
  output logic [7:0] mem_dq_o,
  output logic mem_dq_oe,
  input wire logic [7:0] mem_dq_i,
  output logic mem_chip_sel_n,
  output logic mem_write_n,
  output logic mem_read_n,
  output logic protect_lock_n,
  input wire logic mem_ready_n
);
  import eeprom_page_host_pkg::*;

  host_state_t state_ff;
  done_mode_t mode_ff;
  logic [9:0] page_ff;
  logic [6:0] last_ff;
  logic [6:0] ofs_ff;
  logic [31:0] cnt_ff;
  logic [31:0] gap_ff;
  logic last_top_ff;
  logic prev_tog_ff;
  logic first_read_ff;

  function automatic logic [31:0] cyc(input logic [31:0] v);
    cyc = v - 32'h1;
  endfunction

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      mode_ff <= MODE_WAIT;
      page_ff <= 10'h000;
      last_ff <= 7'h00;
      ofs_ff <= 7'h00;
      cnt_ff <= 32'h0;
      last_top_ff <= 1'b0;
      prev_tog_ff <= 1'b0;
      first_read_ff <= 1'b0;
      page_ready <= 1'b0;
      byte_ready <= 1'b0;
      page_done <= 1'b0;
      mem_addr <= 17'h00000;
      mem_dq_o <= 8'h00;
      mem_dq_oe <= 1'b0;
      mem_chip_sel_n <= 1'b1;
      mem_write_n <= 1'b1;
      mem_read_n <= 1'b1;
      busy <= 1'b0;
    end else begin
      page_done <= 1'b0;
      cnt_ff <= cnt_ff + 32'h1;
      case (state_ff)
        ST_IDLE: begin
          page_ready <= protect_lock_n;
          if (page_ready && page_valid) begin
            page_ready <= 1'b0;
            page_ff <= page_select_address;
            last_ff <= page_count_m1;
            mode_ff <= done_mode;
            ofs_ff <= 7'h00;
            byte_ready <= 1'b1;
            busy <= 1'b1;
            state_ff <= ST_SETUP;
            cnt_ff <= 32'h0;
          end
        end
        ST_SETUP: begin
          if (byte_ready && byte_valid) begin
            byte_ready <= 1'b0;
            mem_addr <= {page_ff, ofs_ff};
            mem_dq_o <= byte_data;
            mem_dq_oe <= 1'b1;
            last_top_ff <= byte_data[`POLL_BIT];
            mem_chip_sel_n <= 1'b0;
            mem_write_n <= 1'b0;
            cnt_ff <= 32'h0;
            state_ff <= ST_STROBE;
          end else if (ofs_ff != 7'h00 && gap_ff >= cyc(`LOAD_WINDOW_CYC - `STROBE_CYC)) begin
            // Source too slow: close the page early rather than break the window
            byte_ready <= 1'b0;
            cnt_ff <= 32'h0;
            state_ff <= ST_GAP;
          end
        end
        ST_STROBE: begin
          if (cnt_ff == cyc(`STROBE_CYC)) begin
            mem_write_n <= 1'b1;
            mem_chip_sel_n <= 1'b1;
            cnt_ff <= 32'h0;
            if (ofs_ff == last_ff) begin
              state_ff <= ST_GAP;
            end else begin
              ofs_ff <= ofs_ff + 7'h01;
              byte_ready <= 1'b1;
              state_ff <= ST_SETUP;
            end
          end
        end
        ST_GAP: begin
          mem_dq_oe <= 1'b0;
          // Idle time counts from the last strobe rise, or from the early close out of ST_SETUP; polling earlier could read a stale cell
          if (cnt_ff >= cyc(`BYTE_LOAD_GAP_CYC)) begin
            cnt_ff <= 32'h0;
            state_ff <= ST_START;
          end
        end
        ST_START: begin
          if (cnt_ff == cyc(`START_DELAY_CYC)) begin
            cnt_ff <= 32'h0;
            first_read_ff <= 1'b1;
            state_ff <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (mode_ff == MODE_WAIT) begin
            // Blind wait ignores the status pins and always pays the worst-case time
            if (cnt_ff >= cyc(`PROGRAM_CYCLE_CYC)) begin
              page_done <= 1'b1;
              busy <= 1'b0;
              state_ff <= ST_IDLE;
            end
          end else if (mode_ff == MODE_READY) begin
            if (mem_ready_n) begin
              page_done <= 1'b1;
              busy <= 1'b0;
              state_ff <= ST_IDLE;
            end
          end else if (cnt_ff >= cyc(`SETUP_CYC)) begin
            mem_addr <= {page_ff, 7'h00};
            mem_chip_sel_n <= 1'b0;
            mem_read_n <= 1'b0;
            cnt_ff <= 32'h0;
            state_ff <= ST_READ;
          end
        end
        ST_READ: begin
          if (cnt_ff == cyc(`READ_CYC)) begin
            mem_chip_sel_n <= 1'b1;
            mem_read_n <= 1'b1;
            cnt_ff <= 32'h0;
            first_read_ff <= 1'b0;
            prev_tog_ff <= mem_dq_i[`TOGGLE_BIT];
            state_ff <= ST_BUSY;
            if (mode_ff == MODE_TOGGLE) begin
              // First read only seeds the reference; the ending level is not fixed
              if (!first_read_ff && mem_dq_i[`TOGGLE_BIT] == prev_tog_ff) begin
                page_done <= 1'b1;
                busy <= 1'b0;
                state_ff <= ST_IDLE;
              end
            end else if (mem_dq_i[`POLL_BIT] == last_top_ff) begin
              page_done <= 1'b1;
              busy <= 1'b0;
              state_ff <= ST_IDLE;
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // Protect lifts one edge after reset so no stray strobe can program the device
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      protect_lock_n <= 1'b0;
    end else begin
      protect_lock_n <= 1'b1;
    end
  end

  // Cycles since the last falling write strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gap_ff <= 32'h0;
    end else if (state_ff == ST_SETUP && byte_ready && byte_valid) begin
      gap_ff <= 32'h0;
    end else if (gap_ff != 32'hFFFFFFFF) begin
      gap_ff <= gap_ff + 32'h1;
    end
  end
endmodule
`default_nettype wire

/* rtl/eeprom_page_host_defs.svh */
// Timing and field constants for the page-write host controller
`ifndef EEPROM_PAGE_HOST_DEFS_SVH
`define EEPROM_PAGE_HOST_DEFS_SVH
`define CLK_PERIOD_NS 10
`define PAGE_BYTES 128
`define LOAD_WINDOW_US 30
`define LOAD_WINDOW_CYC ((`LOAD_WINDOW_US * 1000) / `CLK_PERIOD_NS)
`define BYTE_LOAD_GAP_US 100
`define BYTE_LOAD_GAP_CYC ((`BYTE_LOAD_GAP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROGRAM_CYCLE_MS 10
`define PROGRAM_CYCLE_CYC ((`PROGRAM_CYCLE_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define START_DELAY_NS 150
`define START_DELAY_CYC ((`START_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CYC 30
`define SETUP_CYC 11
`define READ_CYC 16
`define TOGGLE_BIT 6
`define POLL_BIT 7
`define OFS_BITS 7
`endif

/* rtl/eeprom_page_host_pkg.sv */
// Types for the page-write host controller
`default_nettype none
package eeprom_page_host_pkg;
  typedef enum logic [1:0] {
    MODE_WAIT = 2'b00,
    MODE_TOGGLE = 2'b01,
    MODE_POLL = 2'b10,
    MODE_READY = 2'b11
  } done_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_GAP = 3'b011,
    ST_START = 3'b100,
    ST_BUSY = 3'b101,
    ST_READ = 3'b110
  } host_state_t;
endpackage
`default_nettype wire

/* dv/eeprom_page_host_assertions.sv */
// Port checker for the page-write host controller
`timescale 1ns/100ps
`default_nettype none
module eeprom_page_host_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic page_ready,
  input wire logic page_done,
  input wire logic busy,
  input wire logic [16:0] mem_addr,
  input wire logic mem_dq_oe,
  input wire logic mem_chip_sel_n,
  input wire logic mem_write_n,
  input wire logic mem_read_n,
  input wire logic protect_lock_n,
  input wire logic mem_ready_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_wr_len; $fell(mem_write_n) |-> ##29 !mem_write_n ##1 mem_write_n; endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe width wrong");
  property p_wr_bus; $fell(mem_write_n) |-> mem_dq_oe && !mem_chip_sel_n && mem_read_n; endproperty
  a_wr_bus: assert property (p_wr_bus) else $error("write strobe without bus");
  property p_hold; !mem_write_n && !$past(mem_write_n) |-> $stable(mem_addr); endproperty
  a_hold: assert property (p_hold) else $error("address moved in strobe");
  property p_quiet; $rose(mem_write_n) |-> mem_read_n [*8]; endproperty
  a_quiet: assert property (p_quiet) else $error("read right after load");
  property p_rd_at; !mem_read_n |-> mem_addr[6:0] == 7'h00 && !mem_dq_oe; endproperty
  a_rd_at: assert property (p_rd_at) else $error("poll read moved");
  property p_done; page_done |-> mem_ready_n ##1 !busy; endproperty
  a_done: assert property (p_done) else $error("done while device busy");
  property p_idle; page_ready |-> !busy; endproperty
  a_idle: assert property (p_idle) else $error("page taken while busy");
  property p_lock; busy |-> protect_lock_n; endproperty
  a_lock: assert property (p_lock) else $error("locked during access");
  cover property (page_done);
  cover property ($fell(mem_ready_n));
  cover property (!mem_read_n);
endmodule
bind eeprom_page_host eeprom_page_host_checker u_chk (.*);
`default_nettype wire

/* dv/eeprom_dev_model.sv */
// Behavioural page-mode EEPROM on the far side of the host
`timescale 1ns/100ps
`default_nettype none
module eeprom_dev_model #(parameter int PROG_CYC = 300) (
  input wire logic clk,
  input wire logic [16:0] addr,
  input wire logic [7:0] din,
  output logic [7:0] dout,
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic rd_n,
  input wire logic lock_n,
  output logic ready_n
);
  logic [7:0] mem [0:127];
  logic [7:0] last = 8'h00;
  logic [9:0] page = 10'h000;
  logic tog = 1'b0, ld = 1'b0, rd_q = 1'b1, we_q = 1'b1, low = 1'b0;
  int gap = 0, prog = 0;
  wire logic [7:0] rv = (prog > 0) ? {~last[7], tog, 6'h00} : mem[addr[6:0]];
  // Released bus shows the inverse so a stale value cannot pass
  assign dout = (!rd_n && !cs_n && lock_n) ? rv : ~rv;
  assign ready_n = !low;
  always @(posedge clk) begin
    we_q <= we_n;
    rd_q <= rd_n;
    if (!lock_n) begin
      ld <= 0; prog <= 0; low <= 0;
    end else begin
      if (!we_n && !cs_n) begin
        if (we_q) begin page <= addr[16:7]; gap <= 0; end
        mem[addr[6:0]] <= din; last <= din; ld <= 1; low <= 1;
      end else if (ld) begin
        gap <= gap + 1;
        if (gap == 9999) begin ld <= 0; prog <= PROG_CYC; tog <= 1; end
      end
      if (prog > 0) begin prog <= prog - 1; if (prog == 1) low <= 0; end
      if (rd_n && !rd_q && prog > 0) tog <= ~tog;
    end
  end
endmodule
`default_nettype wire

/* dv/eeprom_page_host_tb_top.sv */
// Self-checking bench for the page-write host controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module eeprom_page_host_tb_top;
  import eeprom_page_host_pkg::*;
  logic clk = 0, reset = 1, page_valid = 0, byte_valid = 0;
  logic [9:0] page_select_address = 10'h000;
  logic [6:0] page_count_m1 = 7'h00;
  logic [7:0] byte_data = 8'h00, mem_dq_i, mem_dq_o, dev_q;
  done_mode_t done_mode = MODE_TOGGLE;
  logic page_ready, byte_ready, page_done, busy, mem_dq_oe, mem_chip_sel_n;
  logic mem_write_n, mem_read_n, protect_lock_n, mem_ready_n;
  logic [16:0] mem_addr;
  int bad_count = 0, checks = 0;
  always #5 clk = ~clk;
  assign mem_dq_i = mem_dq_oe ? mem_dq_o : dev_q;
  eeprom_page_host uut (.*);
  eeprom_dev_model dev (.clk(clk), .addr(mem_addr), .din(mem_dq_i), .dout(dev_q),
    .cs_n(mem_chip_sel_n), .we_n(mem_write_n), .rd_n(mem_read_n), .lock_n(protect_lock_n),
    .ready_n(mem_ready_n));
  task automatic give_verdict;
    if (bad_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tmo(input logic ok);
    if (!ok) begin bad_count++; give_verdict; end
  endtask
  task automatic write_page(input done_mode_t m, input logic [9:0] p, input int n);
    int k;
    @(negedge clk);
    done_mode = m; page_select_address = p; page_count_m1 = 7'(n - 1); page_valid = 1;
    for (k = 0; k < 100 && !page_ready; k++) @(negedge clk);
    tmo(page_ready);
    @(negedge clk);
    page_valid = 0;
    `CHK(busy, 1'b1)
    for (int i = 0; i < n; i++) begin
      byte_valid = 1;
      byte_data = 8'(i * 37 + n + 128);
      for (k = 0; k < 100 && !byte_ready; k++) @(negedge clk);
      tmo(byte_ready);
      @(negedge clk);
    end
    byte_valid = 0;
    for (k = 0; k < 30000 && page_done !== 1'b1; k++) @(negedge clk);
    tmo(page_done);
    `CHK(busy, 1'b0)
    `CHK(mem_ready_n, 1'b1)
    `CHK(dev.prog == 0, 1'b1)
    `CHK(dev.page, p)
    for (int i = 0; i < n; i++) `CHK(dev.mem[i], 8'(i * 37 + n + 128))
  endtask
  // Three bytes, toggle polling on data bit 6
  task automatic sc_toggle; write_page(MODE_TOGGLE, 10'h3A5, 3); endtask
  // Single byte with top bit set, inverted-data polling
  task automatic sc_poll; write_page(MODE_POLL, 10'h001, 1); endtask
  // Full page, completion by the ready line
  task automatic sc_ready; write_page(MODE_READY, 10'h2FF, 128); endtask
  // Blind wait outlasts the device, then a mid-run reset drops the page
  task automatic sc_wait_reset;
    int k;
    @(negedge clk);
    done_mode = MODE_WAIT;
    page_select_address = 10'h155;
    page_count_m1 = 7'h00;
    page_valid = 1;
    for (k = 0; k < 100 && !page_ready; k++) @(negedge clk);
    tmo(page_ready);
    @(negedge clk);
    page_valid = 0;
    byte_valid = 1;
    byte_data = 8'h5A;
    for (k = 0; k < 100 && !byte_ready; k++) @(negedge clk);
    tmo(byte_ready);
    @(negedge clk);
    byte_valid = 0;
    repeat (40) @(negedge clk);
    `CHK(mem_ready_n, 1'b0)
    for (k = 0; k < 20000 && !mem_ready_n; k++) @(negedge clk);
    tmo(mem_ready_n);
    repeat (50) @(negedge clk);
    `CHK(busy, 1'b1)
    `CHK(page_done, 1'b0)
    `CHK(mem_read_n, 1'b1)
    `CHK(dev.mem[0], 8'h5A)
    reset = 1;
    @(negedge clk);
    `CHK(busy, 1'b0)
    `CHK(protect_lock_n, 1'b0)
    `CHK(mem_write_n, 1'b1)
    reset = 0;
    @(negedge clk);
    `CHK(protect_lock_n, 1'b1)
    `CHK(page_ready, 1'b0)
    @(negedge clk);
    `CHK(page_ready, 1'b1)
  endtask
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    reset = 0;
    repeat (3) @(negedge clk);
    `CHK(protect_lock_n, 1'b1)
    sc_toggle;
    sc_poll;
    sc_ready;
    sc_wait_reset;
    give_verdict;
  end
endmodule
`default_nettype wire
